// ===== verilog/acr_pkg.sv
// Purpose: Shared constants and carriers for the converter control block
// Assumes: 8-bit register port, registers at word indices 0 to 6
// Notes: Register indices are local choices; reset values are zero except the channel field, which resets to all ones
package acr_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [2:0] ADDR_SC1 = 3'h0;
  localparam logic [2:0] ADDR_SC2 = 3'h1;
  localparam logic [2:0] ADDR_RH = 3'h2;
  localparam logic [2:0] ADDR_RL = 3'h3;
  localparam logic [2:0] ADDR_CVH = 3'h4;
  localparam logic [2:0] ADDR_CVL = 3'h5;
  localparam logic [2:0] ADDR_CFG = 3'h6;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int SC1_DONE_FLAG = 7;
  localparam int SC1_IRQ_EN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CFE = 5;
  localparam int SC2_CFGT = 4;
  localparam int CFG_LPC = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ICLK_LSB = 0;

  // ***************************************************************
  // Encodings and reset values
  // ***************************************************************
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] ICLK_BUS = 2'h0;
  localparam logic [1:0] ICLK_HALF = 2'h1;
  localparam logic [1:0] ICLK_ALT = 2'h2;
  localparam logic [1:0] ICLK_ASYNC = 2'h3;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [4:0] CH_RST = 5'h1F;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CV_RST = 8'h00;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } acr_state_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acr_bus_req_s;

  typedef struct packed {
    logic low_power;
    logic long_sample;
    logic [1:0] mode;
    logic [4:0] channel;
  } acr_core_cfg_s;

endpackage

// ===== verilog/acr_adc_ctrl.sv
// Purpose: Register and control logic of a successive-approximation converter
// Assumes: Core runs on converter_clock enable pulses, returns core_done pulses
// Notes: All inputs synchronous to clk_sys except the two clock sources
//
// Overview of operation
// - Active flag high from start to finish/abort
// - Software or hardware trigger per select bit
// - Compare only while compare enabled
// - Direction bit picks less or greater-equal
// - High register packs by mode, upper zero
// - Failed compare keeps old result
// - Compare event stores result minus compare
// - High read locks results until low read
// - No interlock in 8-bit mode
// - Mode change invalidates both result registers
// - Low register holds low eight bits
// - Compare high used only 10/12-bit
// - Compare low always against low bits
// - Config bit 7 selects low power
// - Divide field gives 1, 2, 4, 8
// - Config bit 4 selects long sample
// - Mode field encodes 8, 12, 10
// - Input clock field selects source
// - Control one write aborts, restarts only under software trigger
// - Complete flag set and clear conditions
// - All-ones channel stops without extra conversion
module acr_adc_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire acr_pkg::acr_bus_req_s bus_req,
  output logic [7:0] rd_data,
  // Trigger and clock sources
  input wire logic hardware_trigger_in,
  input wire logic alternate_clock,
  input wire logic internal_async_clock,
  // Converter core
  output acr_pkg::acr_core_cfg_s core_cfg,
  output logic converter_clock,
  output logic conv_start,
  output logic conv_abort,
  output logic conversion_active,
  input wire logic core_done,
  input wire logic [11:0] core_result
);

  // ***************************************************************
  // State
  // ***************************************************************
  acr_pkg::acr_state_e state_r;
  acr_pkg::acr_state_e state_nxt;
  logic complete_irq_enable_r;
  logic cont_r;
  logic [4:0] channel_select_r;
  logic conversion_complete_flag_r;
  logic conversion_complete_flag_nxt;
  logic trigger_select_r;
  logic compare_enable_r;
  logic compare_greater_equal_r;
  logic [3:0] cvh_r;
  logic [7:0] cvl_r;
  logic [7:0] cfg_r;
  logic [11:0] res_r;
  logic valid_r;
  logic lock_r;
  logic lock_nxt;
  logic done_q_r;
  logic [11:0] res_q_r;
  logic half_r;
  logic alt_s1_r;
  logic alt_s2_r;
  logic alt_s3_r;
  logic asy_s1_r;
  logic asy_s2_r;
  logic asy_s3_r;
  logic [2:0] div_cnt_r;
  logic hwt_prev_r;
  logic [7:0] rd_nxt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ***************************************************************
  // Address decode
  // ***************************************************************
  wire wr_sc1 = bus_req.wr && (bus_req.addr == acr_pkg::ADDR_SC1);
  wire wr_sc2 = bus_req.wr && (bus_req.addr == acr_pkg::ADDR_SC2);
  wire wr_cvh = bus_req.wr && (bus_req.addr == acr_pkg::ADDR_CVH);
  wire wr_cvl = bus_req.wr && (bus_req.addr == acr_pkg::ADDR_CVL);
  wire wr_cfg = bus_req.wr && (bus_req.addr == acr_pkg::ADDR_CFG);
  wire rd_rh = bus_req.rd && (bus_req.addr == acr_pkg::ADDR_RH);
  wire rd_rl = bus_req.rd && (bus_req.addr == acr_pkg::ADDR_RL);
  wire [4:0] wd_channel = bus_req.wdata[4:0];
  wire [1:0] mode = cfg_r[acr_pkg::CFG_MODE_LSB +: 2];
  wire [1:0] div_sel = cfg_r[acr_pkg::CFG_DIV_LSB +: 2];
  wire [1:0] iclk_sel = cfg_r[acr_pkg::CFG_ICLK_LSB +: 2];
  wire mode_8 = (mode == acr_pkg::MODE_8);
  wire mode_10 = (mode == acr_pkg::MODE_10);
  wire converting = (state_r == acr_pkg::ST_CONV);

  // ***************************************************************
  // Converter clock source and divider
  // ***************************************************************
  // The alternate and async sources are sampled and edge detected;
  // they must run well below half of clk_sys.
  wire alt_edge = alt_s2_r && !alt_s3_r;
  wire asy_edge = asy_s2_r && !asy_s3_r;
  wire src_tick = (iclk_sel == acr_pkg::ICLK_BUS) ? 1'b1 :
                  (iclk_sel == acr_pkg::ICLK_HALF) ? half_r :
                  (iclk_sel == acr_pkg::ICLK_ALT) ? alt_edge : asy_edge;
  wire [2:0] div_max = 3'((4'h1 << div_sel) - 4'h1);
  wire div_wrap = (div_cnt_r >= div_max);
  wire conv_tick = src_tick && div_wrap;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      half_r <= 1'b0;
      div_cnt_r <= 3'h0;
    end else begin
      half_r <= !half_r;
      if (src_tick) begin
        div_cnt_r <= div_wrap ? 3'h0 : div_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      alt_s1_r <= 1'b0;
      alt_s2_r <= 1'b0;
      alt_s3_r <= 1'b0;
      asy_s1_r <= 1'b0;
      asy_s2_r <= 1'b0;
      asy_s3_r <= 1'b0;
    end else begin
      alt_s1_r <= alternate_clock;
      alt_s2_r <= alt_s1_r;
      alt_s3_r <= alt_s2_r;
      asy_s1_r <= internal_async_clock;
      asy_s2_r <= asy_s1_r;
      asy_s3_r <= asy_s2_r;
    end
  end

  // ***************************************************************
  // Triggers and conversion sequencing
  // ***************************************************************
  // Trigger level only looked at on converter clock ticks, so one
  // long pulse starts one conversion.
  wire hwt_edge = conv_tick && hardware_trigger_in && !hwt_prev_r;
  wire chan_on = (channel_select_r != acr_pkg::CH_OFF);
  wire done_v = done_q_r && converting && !wr_sc1;
  wire sc1_start = wr_sc1 && (wd_channel != acr_pkg::CH_OFF) && !trigger_select_r;
  wire hw_start = !converting && trigger_select_r && chan_on && hwt_edge && !wr_sc1;
  wire cont_restart = done_v && cont_r && chan_on;
  wire start_any = sc1_start || hw_start || cont_restart;
  wire abort_any = wr_sc1 && converting;

  always_comb begin
    state_nxt = state_r;
    if (start_any) begin
      state_nxt = acr_pkg::ST_CONV;
    end else if (wr_sc1 || done_v) begin
      state_nxt = acr_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= acr_pkg::ST_IDLE;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conversion_active <= 1'b0;
      converter_clock <= 1'b0;
      hwt_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      conv_start <= start_any;
      conv_abort <= abort_any;
      conversion_active <= (state_nxt == acr_pkg::ST_CONV);
      converter_clock <= conv_tick;
      if (conv_tick) begin
        hwt_prev_r <= hardware_trigger_in;
      end
    end
  end

  // Core events pass one register stage before touching software state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_q_r <= 1'b0;
      res_q_r <= 12'h000;
    end else begin
      done_q_r <= core_done;
      res_q_r <= core_result;
    end
  end

  // ***************************************************************
  // Compare and result packing
  // ***************************************************************
  wire [11:0] res_m = mode_8 ? {4'h0, res_q_r[7:0]} :
                      mode_10 ? {2'h0, res_q_r[9:0]} : res_q_r;
  wire [11:0] cv = mode_8 ? {4'h0, cvl_r} :
                   mode_10 ? {2'h0, cvh_r[1:0], cvl_r} : {cvh_r, cvl_r};
  wire [11:0] width_mask = mode_8 ? 12'h0FF : mode_10 ? 12'h3FF : 12'hFFF;
  wire res_less = (res_m < cv);
  wire cmp_true = compare_greater_equal_r ? !res_less : res_less;
  wire keep_ok = !compare_enable_r || cmp_true;
  wire [11:0] diff = (res_m - cv) & width_mask;
  wire [11:0] store_val = compare_enable_r ? diff : res_m;
  wire blocked = lock_r && !mode_8;
  wire xfer = done_v && keep_ok && !blocked;
  wire complete_set = done_v && keep_ok;
  wire mode_chg = wr_cfg && (bus_req.wdata[acr_pkg::CFG_MODE_LSB +: 2] != mode);

  // Set wins over a clear in the same cycle
  always_comb begin
    conversion_complete_flag_nxt = conversion_complete_flag_r;
    if (complete_set) begin
      conversion_complete_flag_nxt = 1'b1;
    end else if (wr_sc1 || rd_rl) begin
      conversion_complete_flag_nxt = 1'b0;
    end
  end

  always_comb begin
    lock_nxt = lock_r;
    if (mode_chg || rd_rl) begin
      lock_nxt = 1'b0;
    end else if (rd_rh && !mode_8) begin
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      res_r <= 12'h000;
      valid_r <= 1'b0;
      lock_r <= 1'b0;
      conversion_complete_flag_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      conversion_complete_flag_r <= conversion_complete_flag_nxt;
      if (xfer) begin
        res_r <= store_val;
        valid_r <= 1'b1;
      end else if (mode_chg) begin
        valid_r <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Software registers
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      complete_irq_enable_r <= 1'b0;
      cont_r <= 1'b0;
      channel_select_r <= acr_pkg::CH_RST;
      trigger_select_r <= 1'b0;
      compare_enable_r <= 1'b0;
      compare_greater_equal_r <= 1'b0;
      cvh_r <= 4'h0;
      cvl_r <= acr_pkg::CV_RST;
      cfg_r <= acr_pkg::CFG_RST;
    end else begin
      if (wr_sc1) begin
        complete_irq_enable_r <= bus_req.wdata[acr_pkg::SC1_IRQ_EN];
        cont_r <= bus_req.wdata[acr_pkg::SC1_CONT];
        channel_select_r <= wd_channel;
      end
      if (wr_sc2) begin
        trigger_select_r <= bus_req.wdata[acr_pkg::SC2_TRG];
        compare_enable_r <= bus_req.wdata[acr_pkg::SC2_CFE];
        compare_greater_equal_r <= bus_req.wdata[acr_pkg::SC2_CFGT];
      end
      if (wr_cvh) begin
        cvh_r <= bus_req.wdata[3:0];
      end
      if (wr_cvl) begin
        cvl_r <= bus_req.wdata;
      end
      if (wr_cfg) begin
        cfg_r <= bus_req.wdata;
      end
    end
  end

  // ***************************************************************
  // Read path and core configuration
  // ***************************************************************
  wire [7:0] sc1_rd = {conversion_complete_flag_r, complete_irq_enable_r, cont_r, channel_select_r};
  wire [7:0] sc2_rd = {conversion_active, trigger_select_r, compare_enable_r,
                       compare_greater_equal_r, 4'h0};
  wire [7:0] rh_rd = valid_r ? {4'h0, res_r[11:8]} : 8'h00;
  wire [7:0] rl_rd = valid_r ? res_r[7:0] : 8'h00;

  always_comb begin
    rd_nxt = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        acr_pkg::ADDR_SC1: rd_nxt = sc1_rd;
        acr_pkg::ADDR_SC2: rd_nxt = sc2_rd;
        acr_pkg::ADDR_RH: rd_nxt = rh_rd;
        acr_pkg::ADDR_RL: rd_nxt = rl_rd;
        acr_pkg::ADDR_CVH: rd_nxt = {4'h0, cvh_r};
        acr_pkg::ADDR_CVL: rd_nxt = cvl_r;
        acr_pkg::ADDR_CFG: rd_nxt = cfg_r;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      core_cfg <= '0;
    end else begin
      rd_data <= rd_nxt;
      core_cfg.low_power <= cfg_r[acr_pkg::CFG_LPC];
      core_cfg.long_sample <= cfg_r[acr_pkg::CFG_LSMP];
      core_cfg.mode <= mode;
      core_cfg.channel <= channel_select_r;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  active_start_a: assert property (conv_start |-> conversion_active ##1
    (conversion_active || $past(done_v) || $past(wr_sc1)))
    else $error("active flag dropped without finish or abort");

  sw_start_a: assert property (sc1_start |=> conv_start && conversion_active)
    else $error("software write did not start conversion");

  hw_start_a: assert property (hw_start |=> conv_start ##1
    (!conv_start || $past(cont_restart) || $past(wr_sc1)))
    else $error("hardware edge did not give one start");

  cmp_off_a: assert property (done_v && !compare_enable_r && !blocked |=>
    valid_r && res_r == $past(res_m))
    else $error("plain result not stored");

  cmp_fail_a: assert property (done_v && compare_enable_r && !cmp_true |=> $stable(res_r))
    else $error("failed compare changed result");

  cmp_diff_a: assert property (xfer && compare_enable_r |=>
    res_r == (($past(res_m) - $past(cv)) & $past(width_mask)))
    else $error("compare event stored wrong difference");

  lock_hold_a: assert property (rd_rh && !mode_8 && !mode_chg ##1 !rd_rl[*2] |->
    $stable(res_r))
    else $error("result changed while locked");

  mode_inval_a: assert property (mode_chg && !xfer |=> !valid_r ##1
    (rd_data == 8'h00 || (!$past(rd_rh) && !$past(rd_rl))))
    else $error("mode change left result valid");

  flag_clear_a: assert property ((wr_sc1 || rd_rl) && !complete_set |=> !conversion_complete_flag_r)
    else $error("complete flag not cleared");

  off_stop_a: assert property (wr_sc1 && wd_channel == acr_pkg::CH_OFF |=>
    !conversion_active ##1 (!conv_start || $past(wr_sc1)))
    else $error("channel off did not stop conversions");

  rh_zero_a: assert property (rd_rh && mode_8 && !$past(mode_chg) |=> rd_data == 8'h00)
    else $error("high result nonzero in 8-bit mode");

endmodule

// ===== sim/acr_core_model.sv
// Purpose: Behavioural converter core answering start pulses
// Assumes: Start and abort are one-cycle pulses on clk_sys
// Notes: Result bus shows the inverse of the last value outside done
module acr_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // From control block
  input wire logic conv_start,
  input wire logic conv_abort,
  // Bench steering
  input wire logic [11:0] next_result,
  input wire logic [7:0] delay,
  // To control block
  output logic core_done,
  output logic [11:0] core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r;
  logic [7:0] cnt_r;
  logic [11:0] last_r;

  // ***************************************************************
  // Conversion timer
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    core_done <= 1'b0;
    // Stale data must not look like a fresh result
    core_result <= ~last_r;
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      last_r <= 12'h000;
    end else if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r <= delay;
    end else if (conv_abort) begin
      busy_r <= 1'b0;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r <= 1'b0;
      core_done <= 1'b1;
      core_result <= next_result;
      last_r <= next_result;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// ===== sim/adc_compare_result_config_tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Core model answers after a bench-chosen delay
// Notes: Results are kept within the mode width
module adc_compare_result_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  acr_pkg::acr_bus_req_s bus_req = '0;
  logic hardware_trigger_in = 1'b0;
  logic alternate_clock = 1'b0;
  logic internal_async_clock = 1'b0;
  logic core_done, converter_clock, conv_start, conv_abort, conversion_active;
  logic [11:0] core_result;
  logic [7:0] rd_data;
  acr_pkg::acr_core_cfg_s core_cfg;
  logic [11:0] next_result = 12'h000;
  logic [7:0] delay = 8'h04;
  logic [7:0] cyc = 8'h00;
  int bad_count = 0;
  int comparisons = 0;
  int n_start = 0;
  int n_abort = 0;
  int n_tick = 0;
  int s0, a0, t0, seed_dummy;
  int base[4] = '{1, 2, 8, 16};
  logic [1:0] mode, m;
  logic [11:0] exp_r, cv, r;
  logic [12:0] res;
  logic [4:0] ch;
  logic cfe, gt, lp, ls;

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 8'h01;
    alternate_clock <= cyc[2];
    internal_async_clock <= cyc[3];
    if (conv_start) n_start <= n_start + 1;
    if (conv_abort) n_abort <= n_abort + 1;
    if (converter_clock) n_tick <= n_tick + 1;
  end

  acr_adc_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .hardware_trigger_in(hardware_trigger_in), .alternate_clock(alternate_clock),
    .internal_async_clock(internal_async_clock), .core_cfg(core_cfg), .converter_clock(converter_clock),
    .conv_start(conv_start), .conv_abort(conv_abort), .conversion_active(conversion_active),
    .core_done(core_done), .core_result(core_result));
  acr_core_model u_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_start(conv_start),
    .conv_abort(conv_abort), .next_result(next_result), .delay(delay), .core_done(core_done),
    .core_result(core_result));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic see(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 chk(what, {4'h0, exp}, {4'h0, rd_data});
  endtask
  // Stored value and hit flag for one completion
  function automatic logic [12:0] model(input logic [1:0] md, input logic [11:0] rv,
      input logic [11:0] cval, input logic en, input logic ge);
    logic [11:0] mask;
    logic [11:0] a;
    logic [11:0] b;
    mask = (md == acr_pkg::MODE_8) ? 12'h0FF : (md == acr_pkg::MODE_10) ? 12'h3FF : 12'hFFF;
    a = rv & mask;
    b = cval & mask;
    return {!en || (ge ? a >= b : a < b), en ? (a - b) & mask : a};
  endfunction
  task automatic run(input logic [11:0] rv, input logic [4:0] c);
    next_result <= rv;
    delay <= 8'($urandom_range(2, 30));
    put(acr_pkg::ADDR_SC1, {3'h0, c});
    #1 chk("active rise", 12'h001, {11'h0, conversion_active});
    for (int i = 0; i < 200 && conversion_active; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("active fall", 12'h000, {11'h0, conversion_active});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    seed_dummy = $urandom(32'hCFF26BA4);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) see(3'(a), (a == 0) ? 8'h1F : 8'h00, "reset value");
    put(acr_pkg::ADDR_SC2, 8'hFF);
    see(acr_pkg::ADDR_SC2, 8'h70, "sc2 access");
    put(acr_pkg::ADDR_CVH, 8'hFF);
    see(acr_pkg::ADDR_CVH, 8'h0F, "cvh access");
    put(acr_pkg::ADDR_RL, 8'hFF);
    see(acr_pkg::ADDR_RL, 8'h00, "rl read only");
    $display("test registers done");
    mode = acr_pkg::MODE_8;
    exp_r = 12'h000;
    for (int i = 0; i < 30; i++) begin
      m = 2'($urandom_range(0, 2));
      if (m !== mode) exp_r = 12'h000;
      mode = m;
      {lp, ls, cfe, gt} = 4'($urandom);
      ch = 5'($urandom_range(0, 30));
      cv = 12'($urandom);
      r = 12'(model(mode, 12'($urandom), 12'h000, 1'b0, 1'b0));
      if (i % 4 == 0) r = 12'(model(mode, cv, 12'h000, 1'b0, 1'b0));
      put(acr_pkg::ADDR_CFG, {lp, 2'b00, ls, mode, 2'b00});
      put(acr_pkg::ADDR_SC2, {2'b00, cfe, gt, 4'h0});
      put(acr_pkg::ADDR_CVH, {4'h0, cv[11:8]});
      put(acr_pkg::ADDR_CVL, cv[7:0]);
      run(r, ch);
      res = model(mode, r, cv, cfe, gt);
      if (res[12]) exp_r = res[11:0];
      chk("core cfg", {3'h0, lp, ls, mode, ch}, {3'h0, core_cfg});
      see(acr_pkg::ADDR_SC1, {res[12], 2'b00, ch}, "complete flag");
      see(acr_pkg::ADDR_RH, {4'h0, exp_r[11:8]}, "result high");
      see(acr_pkg::ADDR_RL, exp_r[7:0], "result low");
      see(acr_pkg::ADDR_SC1, {3'h0, ch}, "flag cleared");
    end
    $display("test compare done");
    put(acr_pkg::ADDR_CFG, {4'h0, acr_pkg::MODE_12, 2'b00});
    put(acr_pkg::ADDR_SC2, 8'h00);
    run(12'hA5C, 5'h01);
    see(acr_pkg::ADDR_RH, 8'h0A, "locked high");
    run(12'h3C7, 5'h01);
    see(acr_pkg::ADDR_SC1, 8'h81, "flag while locked");
    see(acr_pkg::ADDR_RL, 8'h5C, "locked low");
    run(12'h3C7, 5'h01);
    see(acr_pkg::ADDR_RH, 8'h03, "unlocked high");
    see(acr_pkg::ADDR_RL, 8'hC7, "unlocked low");
    put(acr_pkg::ADDR_CFG, {4'h0, acr_pkg::MODE_8, 2'b00});
    run(12'h0B6, 5'h01);
    see(acr_pkg::ADDR_RH, 8'h00, "byte high");
    run(12'h04D, 5'h01);
    see(acr_pkg::ADDR_RL, 8'h4D, "byte no lock");
    $display("test interlock done");
    delay <= 8'h50;
    put(acr_pkg::ADDR_SC1, 8'h23);
    repeat (4) @(posedge clk_sys);
    s0 = n_start;
    a0 = n_abort;
    put(acr_pkg::ADDR_SC1, 8'h24);
    repeat (2) @(posedge clk_sys);
    chk("abort count", 12'(a0 + 1), 12'(n_abort));
    chk("restart count", 12'(s0 + 1), 12'(n_start));
    // Continuous mode: one restart after the 80-cycle conversion ends
    repeat (90) @(posedge clk_sys);
    chk("cont restart", 12'(s0 + 2), 12'(n_start));
    put(acr_pkg::ADDR_SC1, 8'h3F);
    repeat (100) @(posedge clk_sys);
    chk("off start", 12'(s0 + 2), 12'(n_start));
    chk("off active", 12'h000, {11'h0, conversion_active});
    see(acr_pkg::ADDR_SC1, 8'h3F, "off no flag");
    $display("test abort done");
    put(acr_pkg::ADDR_SC2, 8'h40);
    s0 = n_start;
    put(acr_pkg::ADDR_SC1, 8'h02);
    repeat (3) @(posedge clk_sys);
    chk("no soft start", 12'(s0), 12'(n_start));
    delay <= 8'h06;
    next_result <= 12'h077;
    hardware_trigger_in <= 1'b1;
    repeat (80) @(posedge clk_sys);
    chk("one hard start", 12'(s0 + 1), 12'(n_start));
    see(acr_pkg::ADDR_RL, 8'h77, "hard result");
    hardware_trigger_in <= 1'b0;
    $display("test trigger done");
    for (int k = 0; k < 16; k++) begin
      put(acr_pkg::ADDR_CFG, {1'b0, 2'(k), 3'h0, 2'(k >> 2)});
      repeat (300) @(posedge clk_sys);
      t0 = n_tick;
      repeat (256) @(posedge clk_sys);
      chk("tick count", 12'(256 / (base[k >> 2] << (k % 4))), 12'(n_tick - t0));
    end
    $display("test clock done");
    conclude();
  end
endmodule
